// file: rtl/irq_flags_regs.svh
/*
 * Register offsets, field positions, reset values and writable masks
 * for the interrupt request flag block. Assumes APB byte addressing.
 */
`ifndef IRQ_FLAGS_REGS_SVH
`define IRQ_FLAGS_REGS_SVH

// ====================================================================
// Register offsets (byte addresses)
`define OFS_FLAGS_ONE 12'h000
`define OFS_FLAGS_TWO 12'h004
`define OFS_ENABLE_ONE 12'h008
`define OFS_ENABLE_TWO 12'h00c
`define OFS_EDGE_SEL 12'h010
`define OFS_PIN_MODE 12'h014
`define OFS_PENDING 12'h018

// ====================================================================
// Field positions
`define BIT_INTERVAL 7
`define BIT_SERIAL 6
`define BIT_ONE_FIXED 5
`define BIT_DIRECT 7
`define BIT_CONVERT 6
`define BIT_TWO_ZERO 5
`define BIT_CAPTURE 4
`define BIT_HIGH_CMP 3
`define BIT_LOW_CMP 2

// ====================================================================
// Reset values and writable masks
`define RST_FLAGS_ONE 8'h20
`define RST_FLAGS_TWO 8'h01
`define RST_ENABLE_ONE 8'h00
`define RST_ENABLE_TWO 8'h01
`define RST_EDGE_SEL 8'h00
`define RST_PIN_MODE 8'h00
`define MASK_FLAGS_ONE 8'hdf
`define MASK_FLAGS_TWO 8'hdc
`define MASK_ENABLE_ONE 8'hff
`define MASK_ENABLE_TWO 8'hdc
`define MASK_EDGE_SEL 8'h1f
`define NUM_PINS 5

`endif

// file: rtl/irq_flags_pkg.sv
/*
 * Types shared by the interrupt request flag block.
 * Assumes the constants header is included by users of offsets.
 */
package irq_flags_pkg;

    // Peripheral event pulses, one clock wide, same clock domain
    typedef struct packed {
        logic interval_wrap;
        logic serial_done;
        logic direct_transfer;
        logic conversion_done;
        logic capture_edge;
        logic capture_wrap;
        logic capture_wrap_en;
        logic high_match;
        logic low_match;
    } periph_events_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_SETUP = 2'b01,
        BUS_ACCESS = 2'b10
    } bus_state_t;

endpackage

// file: rtl/edge_detect.sv
/*
 * Synchroniser and selectable edge detector for the external request pins.
 * Assumes pins are asynchronous to i_clk.
 */
`timescale 1ns/1ps
module edge_detect #(
    parameter int N = 5
) (
    input wire logic i_clk, // System clock
    input wire logic i_rst_n, // Synchronised reset, active low
    input wire logic [N-1:0] i_pin, // Raw pin levels
    input wire logic [N-1:0] i_rise, // 1 rising, 0 falling
    output logic [N-1:0] o_edge // One-cycle edge pulse
);
    logic [N-1:0] meta_reg;
    logic [N-1:0] sync_reg;
    logic [N-1:0] last_reg;
    logic [N-1:0] edge_next;

    // ================================================================
    // Detection
    always_comb begin
        edge_next = '0;
        for (int k = 0; k < N; k++) begin
            if (i_rise[k]) begin
                edge_next[k] = sync_reg[k] & ~last_reg[k];
            end else begin
                edge_next[k] = ~sync_reg[k] & last_reg[k];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_reg <= '1;
            sync_reg <= '1;
            last_reg <= '1;
            o_edge <= '0;
        end else begin
            meta_reg <= i_pin;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
            o_edge <= edge_next;
        end
    end
endmodule // edge_detect

// file: rtl/irq_request_flags.sv
/*
 * Interrupt request flag registers with enables, edge select and APB slave.
 * Assumes peripheral event pulses are synchronous to i_clk and one cycle wide.
 */
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "irq_flags_regs.svh"
module irq_request_flags
    import irq_flags_pkg::*;
(
    input wire logic i_clk, // System clock, 50 MHz
    input wire logic i_rstn, // Asynchronous reset, active low
    input wire logic i_psel, // APB select
    input wire logic i_penable, // APB enable
    input wire logic i_pwrite, // APB write
    input wire logic [11:0] i_paddr, // APB byte address
    input wire logic [31:0] i_pwdata, // APB write data
    output logic [31:0] o_prdata, // APB read data
    output logic o_pready, // APB ready
    output logic o_pslverr, // APB error, unmapped address
    input wire periph_events_t i_events, // Peripheral event pulses
    input wire logic [4:0] i_ext_pin, // External request pins, asynchronous
    output logic [7:0] o_req_one, // Requests of first register group
    output logic [7:0] o_req_two, // Requests of second register group
    output logic o_irq // Any enabled request pending
);
    logic rst_meta_reg;
    logic rst_n;
    logic [7:0] flags_one_reg, flags_one_next;
    logic [7:0] flags_two_reg, flags_two_next;
    logic [7:0] enable_one_reg, enable_one_next;
    logic [7:0] enable_two_reg, enable_two_next;
    logic [7:0] edge_sel_reg, edge_sel_next;
    logic [7:0] pin_mode_reg, pin_mode_next;
    logic [31:0] prdata_next;
    logic pready_next, pslverr_next;
    logic [7:0] req_one_next, req_two_next;
    logic [4:0] pin_edge;
    logic access;
    logic wr_ok;
    logic [7:0] wbyte;

    // Address decode shared by read and write paths
    function automatic logic mapped(input logic [11:0] a);
        case (a)
            `OFS_FLAGS_ONE, `OFS_FLAGS_TWO, `OFS_ENABLE_ONE, `OFS_ENABLE_TWO,
            `OFS_EDGE_SEL, `OFS_PIN_MODE, `OFS_PENDING: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction

    // ================================================================
    // Reset release
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    // ================================================================
    // Pin edges
    // edge polarity select
    edge_detect #(.N(`NUM_PINS)) u_edge (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_pin(i_ext_pin),
        .i_rise(edge_sel_reg[4:0]),
        .o_edge(pin_edge)
    );

    // ================================================================
    // Bus and register next state
    assign access = i_psel & i_penable & ~o_pready;
    assign wr_ok = access & i_pwrite & mapped(i_paddr);
    assign wbyte = i_pwdata[7:0];

    always_comb begin
        flags_one_next = flags_one_reg;
        flags_two_next = flags_two_reg;
        enable_one_next = enable_one_reg;
        enable_two_next = enable_two_reg;
        edge_sel_next = edge_sel_reg;
        pin_mode_next = pin_mode_reg;
        if (wr_ok && i_paddr == `OFS_FLAGS_ONE) begin
            flags_one_next = flags_one_reg & (wbyte | ~8'(`MASK_FLAGS_ONE));
        end
        if (wr_ok && i_paddr == `OFS_FLAGS_TWO) begin
            flags_two_next = flags_two_reg & (wbyte | ~8'(`MASK_FLAGS_TWO));
        end
        if (wr_ok && i_paddr == `OFS_ENABLE_ONE) begin
            enable_one_next = wbyte & `MASK_ENABLE_ONE;
        end
        if (wr_ok && i_paddr == `OFS_ENABLE_TWO) begin
            enable_two_next = (wbyte & `MASK_ENABLE_TWO) | `RST_ENABLE_TWO;
        end
        if (wr_ok && i_paddr == `OFS_EDGE_SEL) begin
            edge_sel_next = wbyte & `MASK_EDGE_SEL;
        end
        if (wr_ok && i_paddr == `OFS_PIN_MODE) begin
            pin_mode_next = wbyte & `MASK_EDGE_SEL;
        end
        if (i_events.interval_wrap) flags_one_next[`BIT_INTERVAL] = 1'b1;
        if (i_events.serial_done) flags_one_next[`BIT_SERIAL] = 1'b1;
        flags_one_next[4:0] = flags_one_next[4:0] | (pin_edge & pin_mode_reg[4:0]);
        if (i_events.direct_transfer) flags_two_next[`BIT_DIRECT] = 1'b1;
        if (i_events.conversion_done) flags_two_next[`BIT_CONVERT] = 1'b1;
        if (i_events.capture_edge || (i_events.capture_wrap && i_events.capture_wrap_en)) begin
            flags_two_next[`BIT_CAPTURE] = 1'b1;
        end
        if (i_events.high_match) flags_two_next[`BIT_HIGH_CMP] = 1'b1;
        if (i_events.low_match) flags_two_next[`BIT_LOW_CMP] = 1'b1;
        flags_one_next[`BIT_ONE_FIXED] = 1'b1;
        flags_two_next[`BIT_TWO_ZERO] = 1'b0;
        flags_two_next[1:0] = 2'b01;
    end

    always_comb begin
        req_one_next = flags_one_next & enable_one_next & `MASK_FLAGS_ONE;
        req_two_next = flags_two_next & enable_two_next & `MASK_FLAGS_TWO;
    end

    always_comb begin
        pready_next = access;
        pslverr_next = access & ~mapped(i_paddr);
        prdata_next = 32'h0000_0000;
        if (access && !i_pwrite) begin
            case (i_paddr)
                `OFS_FLAGS_ONE: prdata_next[7:0] = flags_one_reg;
                `OFS_FLAGS_TWO: prdata_next[7:0] = flags_two_reg;
                `OFS_ENABLE_ONE: prdata_next[7:0] = enable_one_reg;
                `OFS_ENABLE_TWO: prdata_next[7:0] = enable_two_reg;
                `OFS_EDGE_SEL: prdata_next[7:0] = edge_sel_reg;
                `OFS_PIN_MODE: prdata_next[7:0] = pin_mode_reg;
                `OFS_PENDING: prdata_next[15:0] = {o_req_two, o_req_one};
                default: prdata_next = 32'h0000_0000;
            endcase
        end
    end

    // ================================================================
    // State registers
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_one_reg <= `RST_FLAGS_ONE;
            flags_two_reg <= `RST_FLAGS_TWO;
            enable_one_reg <= `RST_ENABLE_ONE;
            enable_two_reg <= `RST_ENABLE_TWO;
            edge_sel_reg <= `RST_EDGE_SEL;
            pin_mode_reg <= `RST_PIN_MODE;
            o_prdata <= 32'h0000_0000;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_req_one <= 8'h00;
            o_req_two <= 8'h00;
            o_irq <= 1'b0;
        end else begin
            flags_one_reg <= flags_one_next;
            flags_two_reg <= flags_two_next;
            enable_one_reg <= enable_one_next;
            enable_two_reg <= enable_two_next;
            edge_sel_reg <= edge_sel_next;
            pin_mode_reg <= pin_mode_next;
            o_prdata <= prdata_next;
            o_pready <= pready_next;
            o_pslverr <= pslverr_next;
            o_req_one <= req_one_next;
            o_req_two <= req_two_next;
            o_irq <= |{req_one_next, req_two_next};
        end
    end
endmodule // irq_request_flags

// file: bench/irq_flags_chk.sv
/*
 * Checker that watches the ports of irq_request_flags.
 * Assumes the constants header is on the include path.
 */
`timescale 1ns/1ps
`include "irq_flags_regs.svh"
module irq_flags_chk
    import irq_flags_pkg::*;
(
    input wire logic i_clk, // Clock
    input wire logic i_rstn, // Reset
    input wire logic i_psel, // Select
    input wire logic i_penable, // Enable
    input wire logic i_pwrite, // Write
    input wire logic [11:0] i_paddr, // Address
    input wire logic [31:0] i_pwdata, // Data in
    input wire logic [31:0] o_prdata, // Data out
    input wire logic o_pready, // Ready
    input wire logic o_pslverr, // Error
    input wire periph_events_t i_events, // Events
    input wire logic [4:0] i_ext_pin, // Pins
    input wire logic [7:0] o_req_one, // Requests one
    input wire logic [7:0] o_req_two, // Requests two
    input wire logic o_irq // Interrupt
);
    logic take;
    logic wr_one;
    logic wr_two;
    assign take = i_psel && i_penable && i_pwrite && !o_pready;
    assign wr_one = take && (i_paddr == `OFS_FLAGS_ONE || i_paddr == `OFS_ENABLE_ONE);
    assign wr_two = take && (i_paddr == `OFS_FLAGS_TWO || i_paddr == `OFS_ENABLE_TWO);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // ======================================
    // Assertions
    ready_one_cycle_a: assert property (o_pready |=> !o_pready)
        else $error("ready held too long");
    ready_answer_a: assert property (i_psel && i_penable && !o_pready |=> o_pready)
        else $error("ready late");
    err_with_ready_a: assert property (o_pslverr |-> o_pready)
        else $error("error without ready");
    fixed_masked_a: assert property (o_req_one[5] == 1'b0 && o_req_two[5] == 1'b0 && o_req_two[1:0] == 2'b00)
        else $error("fixed bit requests");
    irq_is_or_a: assert property (o_irq == (|o_req_one || |o_req_two))
        else $error("irq not or of requests");
    hold_one_a: assert property (!wr_one |=> (o_req_one & $past(o_req_one)) == $past(o_req_one))
        else $error("request one dropped");
    hold_two_a: assert property (!wr_two |=> (o_req_two & $past(o_req_two)) == $past(o_req_two))
        else $error("request two dropped");
    interval_cause_a: assert property ($rose(o_req_one[7]) |-> $past(i_events.interval_wrap) || $past(wr_one))
        else $error("interval request without cause");
    direct_cause_a: assert property ($rose(o_req_two[7]) |-> $past(i_events.direct_transfer) || $past(wr_two))
        else $error("direct request without cause");
    cover property (o_pslverr);
    cover property ($rose(o_irq));
    cover property ($rose(o_req_two[7]));
endmodule // irq_flags_chk
bind irq_request_flags irq_flags_chk u_irq_flags_chk (.i_clk, .i_rstn, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_events, .i_ext_pin, .o_req_one, .o_req_two, .o_irq);

// file: bench/periph_model.sv
/*
 * Peripheral side: turns bench requests into event pulses and pin levels.
 * Assumes the bench holds a request for as long as the event should last.
 */
`timescale 1ns/1ps
module periph_model
    import irq_flags_pkg::*;
(
    input wire logic i_clk, // Clock
    input wire logic [8:0] i_kick, // Wanted events
    input wire logic [4:0] i_lvl, // Wanted pin levels
    output periph_events_t o_events, // Event pulses
    output logic [4:0] o_pin // Pin levels
);
    initial o_events = '0;
    assign o_pin = i_lvl;
    always @(posedge i_clk) begin
        o_events <= periph_events_t'(i_kick);
    end
endmodule // periph_model

// file: bench/tb.sv
/*
 * Self-checking bench for irq_request_flags over APB.
 * Assumes the constants header is on the include path.
 */
`timescale 1ns/1ps
`include "irq_flags_regs.svh"
module tb;
    import irq_flags_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic rdy, err, irq, err_q;
    logic [7:0] req1, req2;
    logic [8:0] kick = 9'h000;
    logic [4:0] lvl = 5'h0a;
    logic [4:0] pin;
    periph_events_t ev;
    logic [11:0] a;
    logic [31:0] b;
    logic [8:0] kicks [8] = '{9'h100, 9'h080, 9'h040, 9'h020, 9'h010, 9'h00c, 9'h002, 9'h001};
    int bits [8] = '{7, 6, 7, 6, 4, 4, 3, 2};
    int fail_count = 0;
    int checks = 0;
    always #10 clk = ~clk;
    irq_request_flags u_irq_request_flags (.i_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdat), .o_prdata(rdat), .o_pready(rdy), .o_pslverr(err),
        .i_events(ev), .i_ext_pin(pin), .o_req_one(req1), .o_req_two(req2), .o_irq(irq));
    periph_model u_periph_model (.i_clk(clk), .i_kick(kick), .i_lvl(lvl), .o_events(ev), .o_pin(pin));
    // ======================================
    // Tasks
    task automatic complete_run;
        $display("fail_count=%0d checks=%0d", fail_count, checks);
        if (fail_count == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        addr <= ad;
        wdat <= d;
        @(posedge clk);
        pen <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (rdy === 1'b1) break;
        end
        q = rdat;
        err_q = err;
        psel <= 1'b0;
        pen <= 1'b0;
        if (n == 20) begin
            fail_count++;
            $display("wrong value at %0t: no ready", $time);
            complete_run();
        end
    endtask
    task automatic wr(input logic [11:0] ad, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, ad, d, q);
    endtask
    task automatic rd(input logic [11:0] ad, input logic [31:0] e);
        logic [31:0] q;
        apb(1'b0, ad, 32'h0, q);
        chk(q, e);
    endtask
    task automatic fire(input logic [8:0] k);
        @(posedge clk);
        kick <= k;
        @(posedge clk);
        kick <= 9'h000;
        repeat (3) @(posedge clk);
    endtask
    // ======================================
    // Sequence
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        rd(`OFS_FLAGS_ONE, 32'h20);
        rd(`OFS_FLAGS_TWO, 32'h01);
        rd(`OFS_ENABLE_ONE, 32'h00);
        rd(`OFS_ENABLE_TWO, 32'h01);
        rd(`OFS_EDGE_SEL, 32'h00);
        rd(12'h01c, 32'h0);
        chk(err_q, 32'h1);
        wr(`OFS_FLAGS_ONE, 32'hff);
        wr(`OFS_FLAGS_TWO, 32'hdf);
        rd(`OFS_FLAGS_ONE, 32'h20);
        rd(`OFS_FLAGS_TWO, 32'h01);
        for (int i = 0; i < 8; i++) begin
            a = (i < 2) ? `OFS_FLAGS_ONE : `OFS_FLAGS_TWO;
            b = (i < 2) ? 32'h20 : 32'h01;
            fire(kicks[i]);
            rd(a, b | (32'h1 << bits[i]));
            wr(a, ~(32'h1 << bits[i]) & 32'hdf);
            rd(a, b);
        end
        fire(9'h008);
        rd(`OFS_FLAGS_TWO, 32'h01);
        wr(`OFS_ENABLE_ONE, 32'hff);
        wr(`OFS_ENABLE_TWO, 32'hdc);
        rd(`OFS_ENABLE_TWO, 32'hdd);
        chk(irq, 32'h0);
        fire(9'h140);
        chk({req2, req1, 7'h0, irq}, 32'h00808001);
        rd(`OFS_PENDING, 32'h8080);
        // Event lands on the very edge at which the clear takes effect
        fork
            wr(`OFS_FLAGS_ONE, 32'h00);
            begin
                @(posedge clk);
                kick <= 9'h100;
                @(posedge clk);
                kick <= 9'h000;
            end
        join
        rd(`OFS_FLAGS_ONE, 32'ha0);
        wr(`OFS_FLAGS_ONE, 32'h00);
        wr(`OFS_FLAGS_TWO, 32'h00);
        chk(irq, 32'h0);
        wr(`OFS_ENABLE_ONE, 32'h00);
        fire(9'h100);
        chk({req1, 7'h0, irq}, 32'h0);
        rd(`OFS_FLAGS_ONE, 32'ha0);
        wr(`OFS_EDGE_SEL, 32'h15);
        wr(`OFS_PIN_MODE, 32'h1f);
        wr(`OFS_FLAGS_ONE, 32'h00);
        lvl <= 5'h15;
        repeat (8) @(posedge clk);
        rd(`OFS_FLAGS_ONE, 32'h3f);
        wr(`OFS_FLAGS_ONE, 32'h00);
        lvl <= 5'h0a;
        repeat (8) @(posedge clk);
        rd(`OFS_FLAGS_ONE, 32'h20);
        wr(`OFS_PIN_MODE, 32'h00);
        lvl <= 5'h15;
        repeat (8) @(posedge clk);
        rd(`OFS_FLAGS_ONE, 32'h20);
        complete_run();
    end
endmodule // tb
